/* acp_defs.svh */
/*
 Constants for the converter's serial command port: field positions of
 the command byte, register select codes, register widths and counts.
 Assumes inclusion by bare name from the design file only.
*/
`ifndef ACP_DEFS_SVH
`define ACP_DEFS_SVH

// command byte layout, first bit shifted is bit 7
`define ACP_CMD_RST     8'h00
`define ACP_GATE_BIT    7
`define ACP_SEL_HI_BIT  5
`define ACP_SEL_LO_BIT  4
`define ACP_DIR_BIT     3
`define ACP_CONTINUOUS_READ_BIT_BIT   2
`define ACP_CH_HI_BIT   1
`define ACP_CH_LO_BIT   0
`define ACP_CMD_LAST    3'h6

// register select codes
`define ACP_SEL_CMD     2'h0
`define ACP_SEL_MODE    2'h1
`define ACP_SEL_FILT    2'h2
`define ACP_SEL_DATA    2'h3

// register widths in bits
`define ACP_W_SHORT     5'h08
`define ACP_W_DATA      5'h18

// status ready flag position, low means result ready
`define ACP_RDY_BIT     7

// ones counted before the final one that resynchronises the part
`define ACP_RESYNC_LAST 5'h1F

`define ACP_FIFO_DEPTH  16

`endif

/* acp_pkg.sv */
/*
 Types for the converter's serial command port.
 Assumes acp_defs.svh supplies the numeric constants.
*/
package acp_pkg;

    typedef enum logic [4:0] {
        ACP_IDLE = 5'h01,
        ACP_CMD  = 5'h02,
        ACP_WR   = 5'h04,
        ACP_RD   = 5'h08,
        ACP_PUSH = 5'h10
    } acp_state_t;

    typedef struct packed {
        logic       write_gate;
        logic       fixed_zero;
        logic [1:0] reg_select;
        logic       read_dir;
        logic       continuous_read_bit;
        logic [1:0] input_select;
    } acp_cmd_t;

    typedef struct packed {
        logic [1:0]  reg_select;
        logic [23:0] data;
    } acp_wr_t;

endpackage

/* acp_serial_port.sv */
/*
 Serial command port of a sigma-delta converter plus the FIFO that
 carries written register words to the converter core.
 Assumes pins are asynchronous to core_clk and that the serial clock
 runs well below a quarter of core_clk.
*/
// How it works
// - pin goes low on conversion done
// - unread result: pin high before update
// - output changes on falling serial edge
// - chip select high: pin off, flag alive
// - status register carries the ready flag
// - input bits go to selected register
// - command register eight bits, write only
// - command picks direction and target register
// - transfer done returns to idle
// - idle after power-up and reset
// - 32 ones reset part and interface
// - command shifted most significant first
// - command fields and zero reset
// - select zero means command register
// - hold at gate bit until zero
// - direction zero write, one read
// - active-low chip select, may be tied
`timescale 1ns/1ps
`include "acp_defs.svh"

////////////////////////////////////////////////////////////////////////
module acp_fifo #(
    parameter int W = 26,
    parameter int D = 16
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         srst,
    // fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // drain side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wp;
    logic [AW:0]  rp;
    logic [AW:0]  next_wp;
    logic [AW:0]  next_rp;
    logic         push;
    logic         pop;

    assign in_ready  = !((wp[AW-1:0] == rp[AW-1:0]) && (wp[AW] != rp[AW]));
    assign out_valid = (wp != rp);
    assign out_data  = mem[rp[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_wp = wp + {{AW{1'b0}}, push};
        next_rp = rp + {{AW{1'b0}}, pop};
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
        end
    end

    // storage needs no reset, pointers guard it
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////
module acp_serial_port (
    // clock and reset
    input  wire logic            core_clk,
    input  wire logic            srst,
    // serial pins
    input  wire logic            sclk_pin,
    input  wire logic            cs_n_pin,
    input  wire logic            din_pin,
    output logic                 dout_o,
    output logic                 dout_oe,
    // converter core
    input  wire logic            conv_done,
    input  wire logic            upd_soon,
    input  wire logic [23:0]     conv_result,
    input  wire logic [6:0]      status_aux,
    input  wire logic [7:0]      mode_val,
    input  wire logic [7:0]      filter_val,
    output logic                 part_reset,
    // command register fields
    output logic                 continuous_read_bit,
    output logic [1:0]           input_select,
    // written register words
    output logic                 wr_valid,
    output acp_pkg::acp_wr_t     wr_word,
    input  wire logic            wr_ready
);
    import acp_pkg::*;

    logic [1:0]  sclk_sync;
    logic [1:0]  cs_sync;
    logic [1:0]  din_sync;
    logic        sclk_d;
    logic        rise;
    logic        fall;
    logic        cs_hi;
    logic        din;

    acp_state_t  state;
    acp_state_t  next_state;
    acp_cmd_t    cmd;
    acp_cmd_t    next_cmd;
    acp_cmd_t    cmd_new;
    logic [4:0]  cnt;
    logic [4:0]  next_cnt;
    logic [4:0]  ones;
    logic [4:0]  next_ones;
    logic [23:0] in_sh;
    logic [23:0] next_in_sh;
    logic [23:0] out_sh;
    logic [23:0] next_out_sh;
    logic        dout_q;
    logic        next_dout_q;
    acp_wr_t     wr_hold;
    acp_wr_t     next_wr_hold;
    logic        resync;
    logic        next_part_reset;
    logic        rd_clr;
    logic        ready;
    logic        next_ready;
    logic        fifo_in_ready;
    logic [23:0] shifted;

    ////////////////////////////////////////////////////////////////////
    function automatic logic [4:0] reg_width(input logic [1:0] sel);
        reg_width = (sel == `ACP_SEL_DATA) ? `ACP_W_DATA : `ACP_W_SHORT;
    endfunction

    // left aligned so the msb always leaves from bit 23
    function automatic logic [23:0] rd_value(input logic [1:0] sel,
                                             input logic       rdy);
        unique case (sel)
            `ACP_SEL_CMD:  rd_value = {~rdy, status_aux, 16'h0000};
            `ACP_SEL_MODE: rd_value = {mode_val, 16'h0000};
            `ACP_SEL_FILT: rd_value = {filter_val, 16'h0000};
            `ACP_SEL_DATA: rd_value = conv_result;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pins are asynchronous: two flops before any use
    always_ff @(posedge core_clk) begin
        if (srst) begin
            // serial clock idles high: reset there, no false rise
            sclk_sync <= 2'h3;
            cs_sync   <= 2'h3;
            din_sync  <= 2'h0;
            sclk_d    <= 1'b1;
        end else begin
            sclk_sync <= {sclk_sync[0], sclk_pin};
            cs_sync   <= {cs_sync[0], cs_n_pin};
            din_sync  <= {din_sync[0], din_pin};
            sclk_d    <= sclk_sync[1];
        end
    end

    assign rise  = sclk_sync[1] && !sclk_d;
    assign fall  = !sclk_sync[1] && sclk_d;
    assign cs_hi = cs_sync[1];
    assign din   = din_sync[1];

    assign shifted = {in_sh[22:0], din};
    assign cmd_new = acp_cmd_t'({1'b0, shifted[6:0]});
    assign resync  = !cs_hi && rise && din && (ones == `ACP_RESYNC_LAST);

    ////////////////////////////////////////////////////////////////////
    // interface sequencer
    always_comb begin
        next_state      = state;
        next_cmd        = cmd;
        next_cnt        = cnt;
        next_in_sh      = in_sh;
        next_out_sh     = out_sh;
        next_wr_hold    = wr_hold;
        next_part_reset = 1'b0;
        rd_clr          = 1'b0;
        next_ones       = ones;
        if (!cs_hi && rise) begin
            next_ones = din ? ones + 5'h01 : 5'h00;
        end
        if (resync) begin
            next_state      = ACP_IDLE;
            next_cmd        = acp_cmd_t'(`ACP_CMD_RST);
            next_ones       = 5'h00;
            next_part_reset = 1'b1;
        end else if (state == ACP_PUSH) begin
            // a full fifo holds the sequencer here
            if (fifo_in_ready) begin
                next_state = ACP_IDLE;
            end
        end else if (cs_hi) begin
            next_state = ACP_IDLE;
        end else if (rise) begin
            unique case (state)
                ACP_IDLE: begin
                    if (!din) begin
                        next_state = ACP_CMD;
                        next_cnt   = 5'h00;
                    end
                end
                ACP_CMD: begin
                    next_in_sh = shifted;
                    next_cnt   = cnt + 5'h01;
                    if (cnt[2:0] == `ACP_CMD_LAST) begin
                        next_cmd = cmd_new;
                        next_cnt = 5'h00;
                        if (cmd_new.read_dir) begin
                            next_state  = ACP_RD;
                            next_out_sh = rd_value(cmd_new.reg_select, ready);
                        end else if (cmd_new.reg_select == `ACP_SEL_CMD) begin
                            next_state = ACP_IDLE;
                        end else begin
                            next_state = ACP_WR;
                        end
                    end
                end
                ACP_WR: begin
                    next_in_sh = shifted;
                    next_cnt   = cnt + 5'h01;
                    if (cnt == reg_width(cmd.reg_select) - 5'h01) begin
                        next_wr_hold.reg_select = cmd.reg_select;
                        next_wr_hold.data = (cmd.reg_select == `ACP_SEL_DATA) ?
                                            shifted : {16'h0000, shifted[7:0]};
                        next_state = ACP_PUSH;
                    end
                end
                ACP_RD: begin
                    next_cnt = cnt + 5'h01;
                    if (cnt == reg_width(cmd.reg_select) - 5'h01) begin
                        next_state = ACP_IDLE;
                        rd_clr     = (cmd.reg_select == `ACP_SEL_DATA);
                    end
                end
                default: next_state = ACP_IDLE;
            endcase
        end else if (fall && state == ACP_RD) begin
            next_out_sh = {out_sh[22:0], 1'b0};
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state      <= ACP_IDLE;
            cmd        <= acp_cmd_t'(`ACP_CMD_RST);
            cnt        <= 5'h00;
            ones       <= 5'h00;
            in_sh      <= 24'h000000;
            out_sh     <= 24'h000000;
            wr_hold    <= '0;
            part_reset <= 1'b0;
        end else begin
            state      <= next_state;
            cmd        <= next_cmd;
            cnt        <= next_cnt;
            ones       <= next_ones;
            in_sh      <= next_in_sh;
            out_sh     <= next_out_sh;
            wr_hold    <= next_wr_hold;
            part_reset <= next_part_reset;
        end
    end

    assign continuous_read_bit = cmd.continuous_read_bit;
    assign input_select        = cmd.input_select;

    ////////////////////////////////////////////////////////////////////
    // ready flag and shared pin; a new result beats any clear
    always_comb begin
        next_ready  = ready;
        next_dout_q = dout_q;
        if (upd_soon || rd_clr || resync) begin
            next_ready = 1'b0;
        end
        if (conv_done) begin
            next_ready = 1'b1;
        end
        if (state == ACP_RD) begin
            if (fall) begin
                next_dout_q = out_sh[23];
            end
        end else begin
            next_dout_q = ~ready;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ready  <= 1'b0;
            dout_q <= 1'b1;
        end else begin
            ready  <= next_ready;
            dout_q <= next_dout_q;
        end
    end

    assign dout_o  = dout_q;
    assign dout_oe = !cs_hi;

    ////////////////////////////////////////////////////////////////////
    acp_fifo #(
        .W ($bits(acp_wr_t)),
        .D (`ACP_FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .srst      (srst),
        .in_valid  (state == ACP_PUSH),
        .in_data   (wr_hold),
        .in_ready  (fifo_in_ready),
        .out_valid (wr_valid),
        .out_data  (wr_word),
        .out_ready (wr_ready)
    );

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    property p_rdy_set;
        conv_done |=> ready;
    endproperty
    a_rdy_set: assert property (p_rdy_set) else $error("ready not set");

    property p_rdy_clr;
        upd_soon && !conv_done |=> !ready ##1 (state == ACP_RD || dout_q);
    endproperty
    a_rdy_clr: assert property (p_rdy_clr) else $error("ready not cleared");

    property p_fall_only;
        state == ACP_RD && $past(state) == ACP_RD && !$past(fall) |-> $stable(dout_q);
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("data moved off fall");

    property p_hiz_flag;
        cs_hi && conv_done |-> !dout_oe ##1 ready;
    endproperty
    a_hiz_flag: assert property (p_hiz_flag) else $error("pin or flag wrong");

    property p_status;
        state == ACP_CMD && rise && !cs_hi && !resync && cnt[2:0] == `ACP_CMD_LAST
            && cmd_new.read_dir && cmd_new.reg_select == `ACP_SEL_CMD
            |=> out_sh[23] == !$past(ready);
    endproperty
    a_status: assert property (p_status) else $error("status flag wrong");

    sequence s_wr_last;
        state == ACP_WR && rise && !cs_hi && !resync
            && cnt == reg_width(cmd.reg_select) - 5'h01;
    endsequence
    sequence s_pushed;
        state == ACP_PUSH && wr_hold.reg_select == $past(cmd.reg_select);
    endsequence
    property p_wr_target;
        s_wr_last |=> s_pushed;
    endproperty
    a_wr_target: assert property (p_wr_target) else $error("write misrouted");

    sequence s_cmd_last;
        state == ACP_CMD && rise && !cs_hi && !resync && cnt[2:0] == `ACP_CMD_LAST;
    endsequence
    property p_dir;
        s_cmd_last ##0 din_sync[1] == din |=> (cmd.read_dir ? state == ACP_RD
            : (state == ACP_IDLE || state == ACP_WR));
    endproperty
    a_dir: assert property (p_dir) else $error("direction decode wrong");

    property p_rd_done;
        state == ACP_RD && rise && !cs_hi && !resync
            && cnt == reg_width(cmd.reg_select) - 5'h01 |=> state == ACP_IDLE;
    endproperty
    a_rd_done: assert property (p_rd_done) else $error("read did not end");

    property p_after_reset;
        $past(srst) |-> state == ACP_IDLE && cmd == acp_cmd_t'(`ACP_CMD_RST);
    endproperty
    a_after_reset: assert property (p_after_reset) else $error("not idle after reset");

    property p_resync;
        resync |=> part_reset && state == ACP_IDLE ##1 !part_reset;
    endproperty
    a_resync: assert property (p_resync) else $error("resync failed");

    property p_gate_hold;
        state == ACP_IDLE && rise && din |=> state == ACP_IDLE;
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("left gate on one");
endmodule

/* acp_host_model.sv */
/*
 Host model for the converter's serial command port: drives chip select,
 serial clock and data in, samples the shared data/ready pin.
 Assumes it shares core_clk with the port and is called from the bench.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module acp_host (
    // clock
    input  wire logic core_clk,
    // pin from device
    input  wire logic dout_o,
    input  wire logic dout_oe,
    // pins to device
    output logic      sclk,
    output logic      cs_n,
    output logic      din
);
    logic oe_bad;

    initial begin
        sclk   = 1'b1;
        cs_n   = 1'b1;
        din    = 1'b1;
        oe_bad = 1'b0;
    end

    // one framed transfer of n bits, msb first; hp is half period in cycles
    task automatic xfer(input logic [63:0] bits, input int n, input int hp, output logic [63:0] rd);
        rd = '0;
        @(posedge core_clk);
        cs_n <= 1'b0;
        repeat (hp) @(posedge core_clk);
        for (int i = n - 1; i >= 0; i--) begin
            sclk <= 1'b0;
            din  <= bits[i];
            repeat (hp) @(posedge core_clk);
            sclk <= 1'b1;
            // sample mid-high: the device output lags the pin by a few cycles
            repeat (hp / 2) @(posedge core_clk);
            rd = {rd[62:0], dout_o};
            if (dout_oe !== 1'b1) oe_bad = 1'b1;
            repeat (hp - hp / 2) @(posedge core_clk);
        end
        cs_n <= 1'b1;
        // released line: no pull, so show the inverse of the last bit
        din  <= ~bits[0];
        repeat (8) @(posedge core_clk);
    endtask
endmodule

/* tb_top.sv */
/*
 Self-checking bench for the converter's serial command port.
 Assumes acp_pkg is compiled first and the host model drives the pins.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module tb_top;
    import acp_pkg::*;

    logic        core_clk;
    logic        srst;
    logic        sclk_pin;
    logic        cs_n_pin;
    logic        din_pin;
    logic        dout_o;
    logic        dout_oe;
    logic        conv_done;
    logic        upd_soon;
    logic [23:0] conv_result;
    logic [6:0]  status_aux;
    logic [7:0]  mode_val;
    logic [7:0]  filter_val;
    logic        part_reset;
    logic        continuous_read_bit;
    logic [1:0]  input_select;
    logic        wr_valid;
    acp_wr_t     wr_word;
    logic        wr_ready;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          seed = 78701;
    acp_wr_t     exp_wr[$];
    logic        exp_rst[$];
    logic [63:0] rd;

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    acp_serial_port DUT (
        .core_clk            (core_clk),
        .srst                (srst),
        .sclk_pin            (sclk_pin),
        .cs_n_pin            (cs_n_pin),
        .din_pin             (din_pin),
        .dout_o              (dout_o),
        .dout_oe             (dout_oe),
        .conv_done           (conv_done),
        .upd_soon            (upd_soon),
        .conv_result         (conv_result),
        .status_aux          (status_aux),
        .mode_val            (mode_val),
        .filter_val          (filter_val),
        .part_reset          (part_reset),
        .continuous_read_bit (continuous_read_bit),
        .input_select        (input_select),
        .wr_valid            (wr_valid),
        .wr_word             (wr_word),
        .wr_ready            (wr_ready)
    );

    acp_host host (
        .core_clk (core_clk),
        .dout_o   (dout_o),
        .dout_oe  (dout_oe),
        .sclk     (sclk_pin),
        .cs_n     (cs_n_pin),
        .din      (din_pin)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_wr(input acp_wr_t got, input acp_wr_t exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // one-cycle pulse on conversion done (1) or update soon (0)
    task automatic pulse(input logic done);
        @(posedge core_clk);
        if (done) begin
            conv_done <= 1'b1;
        end else begin
            upd_soon <= 1'b1;
        end
        @(posedge core_clk);
        conv_done <= 1'b0;
        upd_soon  <= 1'b0;
        cyc(3);
    endtask

    // register write; select 0 loads the command register only
    task automatic wr_reg(input logic [1:0] sel, input logic [23:0] d);
        int          w;
        logic [63:0] b;
        w = (sel == 2'h3) ? 24 : 8;
        b = (64'({4'h0, sel, 2'h0} << 2) << w) | (64'(d) & ((64'h1 << w) - 64'h1));
        if (sel != 2'h0) exp_wr.push_back({sel, 24'(b[23:0] & ((24'h1 << w) - 24'h1))});
        host.xfer(b, 8 + w, 4, rd);
    endtask

    task automatic rd_reg(input logic [1:0] sel, input logic [31:0] exp, input int hp);
        int w;
        w = (sel == 2'h3) ? 24 : 8;
        host.xfer(64'({2'h0, sel, 4'h8}) << w, 8 + w, hp, rd);
        chk_val(32'(rd[23:0] & ((24'h1 << w) - 24'h1)), exp);
    endtask

    // results seen at the ports are matched against the oldest note
    always @(posedge core_clk) begin
        if (!srst && wr_valid === 1'b1 && wr_ready === 1'b1) begin
            if (exp_wr.size() == 0) chk_wr(wr_word, 26'hX);
            else chk_wr(wr_word, exp_wr.pop_front());
        end
        if (!srst && part_reset === 1'b1) begin
            if (exp_rst.size() == 0) chk_val(32'h1, 32'h0);
            else chk_val(32'(exp_rst.pop_front()), 32'h1);
        end
    end

    initial begin
        cyc(60000);
        n_mismatch++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        srst        = 1'b1;
        wr_ready    = 1'b1;
        conv_done   = 1'b0;
        upd_soon    = 1'b0;
        conv_result = 24'($random(seed));
        status_aux  = 7'($random(seed));
        mode_val    = 8'($random(seed));
        filter_val  = 8'($random(seed));
        cyc(16);
        srst <= 1'b0;
        cyc(3);
        chk_val(32'(dout_oe), 32'h0);
        chk_val(32'({dout_o, wr_valid, part_reset}), 32'h4);
        chk_val(32'({continuous_read_bit, input_select}), 32'h0);
        // leading ones are held off at the gate bit
        host.xfer({53'h0, 3'h7, 8'h07}, 11, 4, rd);
        chk_val(32'({continuous_read_bit, input_select}), 32'h7);
        chk_val(32'(wr_valid), 32'h0);
        for (int i = 1; i < 4; i++) wr_reg(2'(i), 24'($random(seed)));
        pulse(1'b1);
        chk_val(32'(dout_o), 32'h0);
        pulse(1'b0);
        chk_val(32'(dout_o), 32'h1);
        pulse(1'b1);
        rd_reg(2'h0, 32'({1'b0, status_aux}), 4);
        rd_reg(2'h1, 32'(mode_val), 4);
        rd_reg(2'h2, 32'(filter_val), 6);
        rd_reg(2'h3, 32'(conv_result), 4);
        cyc(3);
        chk_val(32'(dout_o), 32'h1);
        chk_val(32'(host.oe_bad), 32'h0);
        // fill past depth with the drain stalled, then drain with random stalls
        wr_ready <= 1'b0;
        for (int i = 0; i < 17; i++) wr_reg(2'h1, 24'($random(seed)));
        chk_val(32'(wr_valid), 32'h1);
        for (int i = 0; i < 3000 && exp_wr.size() != 0; i++) begin
            @(posedge core_clk);
            wr_ready <= 1'($random(seed));
        end
        chk_val(32'(exp_wr.size()), 32'h0);
        @(posedge core_clk);
        wr_ready <= 1'b1;
        // a zero-ending command clears the ones count; 31 ones are not enough
        host.xfer({17'h0, 8'h00, 31'h7FFFFFFF, 1'b0, 7'h06}, 47, 4, rd);
        chk_val(32'({continuous_read_bit, input_select}), 32'h6);
        exp_rst.push_back(1'b1);
        host.xfer(64'hFFFFFFFF, 32, 4, rd);
        chk_val(32'({exp_rst.size(), continuous_read_bit, input_select}), 32'h0);
        host.xfer(64'h01, 8, 4, rd);
        chk_val(32'(input_select), 32'h1);
        // reset in mid-run
        @(posedge core_clk);
        srst <= 1'b1;
        cyc(3);
        srst <= 1'b0;
        cyc(3);
        chk_val(32'({dout_o, input_select, wr_valid}), 32'h8);
        cyc(20);
        complete_run();
    end
endmodule
